// [tbcr_defines.vh]
// How it works
// - Seven two-way trigger lines plus clock line
// - Master timebase runs at 20 MHz
// - Clock source selectable, internal after reset
// - Internal timebase may drive bus clock line
// - Backplane variant uses trigger line 7 as clock
// - Lock oscillator to 10 MHz, 1 MHz comparator
// - Phase lock enabled at reset, no setup
// - Any control signal routable to any trigger line
`ifndef TBCR_DEFINES_VH
`define TBCR_DEFINES_VH

// Register byte offsets
`define TBCR_CTRL_OFS 4'h0
`define TBCR_OUT_ROUTE_OFS 4'h4
`define TBCR_IN_ROUTE_OFS 4'h8
`define TBCR_STATUS_OFS 4'hC

// Control fields
`define TBCR_CTRL_SRC_BIT 0
`define TBCR_CTRL_DRIVE_BIT 1
`define TBCR_CTRL_RST 32'h0000_0000
`define TBCR_ROUTE_RST 32'h0000_0000
`define TBCR_FIELD_W 4
`define TBCR_FIELD_EN_BIT 3

// Status fields
`define TBCR_STAT_SRC_BIT 0
`define TBCR_STAT_LOCK_BIT 1
`define TBCR_STAT_SEEN_BIT 2
`define TBCR_STAT_ERR_LSB 8
`define TBCR_STAT_TUNE_LSB 16

// Rates in Hz and derived divides
`define TBCR_CLK_HZ 40000000
`define TBCR_TB_HZ 20000000
`define TBCR_REF_HZ 10000000
`define TBCR_PD_HZ 1000000
`define TBCR_OSC_DIV (`TBCR_TB_HZ / `TBCR_PD_HZ)
`define TBCR_REF_DIV (`TBCR_REF_HZ / `TBCR_PD_HZ)
`define TBCR_PD_CYC (`TBCR_CLK_HZ / `TBCR_PD_HZ)

// Bus responses
`define TBCR_RESP_OKAY 2'h0
`define TBCR_RESP_SLVERR 2'h2

`endif

// [tbcr_peer.sv]
module tbcr_peer (
    input wire [7:0] trig_o,
    input wire [7:0] trig_oe,
    input wire [7:0] drv_en,
    input wire [7:0] drv_val,
    input wire bclk_run,
    output wire [7:0] trig_i,
    output wire ref_clk10_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_q = 1'b0;
    logic bclk = 1'b0;
    logic pat = 1'b0;
    assign ref_clk10_i = ref_q;
    always #50 ref_q = ~ref_q;
    always #7 pat = ~pat;
    always #100 bclk = bclk_run ? ~bclk : 1'b0;
    // Released lines show bclk (line 7 while bclk_run is set), drv_val where drv_en is set, else a changing pattern
    for (genvar k = 0; k < 8; k++) begin : g_line
        assign trig_i[k] = trig_oe[k] ? trig_o[k] : (k == 7 && bclk_run)
            ? bclk : drv_en[k] ? drv_val[k] : pat;
    end
endmodule // tbcr_peer

// [tbcr_phase_cmp.v]
`include "tbcr_defines.vh"

module tbcr_phase_cmp #(
    parameter OSC_DIV = `TBCR_OSC_DIV,
    parameter REF_DIV = `TBCR_REF_DIV,
    parameter PD_CYC = `TBCR_PD_CYC
) (
    input wire aclk,
    input wire aresetn,
    input wire osc_tick,
    input wire ref_rise,
    output reg signed [7:0] err_q,
    output reg signed [15:0] tune_q,
    output reg slip_q,
    output reg locked_q
);
    reg [4:0] osc_div_q;
    reg [3:0] ref_div_q;
    reg [5:0] since_ref_q;
    localparam [31:0] PD_CYC_W = PD_CYC;
    localparam [7:0] PD_CYC_B = PD_CYC_W[7:0];
    wire osc_pd = osc_tick && (osc_div_q == OSC_DIV - 1);
    wire ref_pd = ref_rise && (ref_div_q == REF_DIV - 1);
    wire signed [7:0] err_now = (since_ref_q >= PD_CYC / 2) ?
        $signed({2'b00, since_ref_q}) - $signed(PD_CYC_B) :
        $signed({2'b00, since_ref_q});

    always @(posedge aclk) begin
        if (!aresetn) begin
            osc_div_q <= 5'h0;
            ref_div_q <= 4'h0;
            since_ref_q <= 6'h00;
            err_q <= 8'sh00;
            tune_q <= 16'sh0000;
            slip_q <= 1'b0;
            locked_q <= 1'b0;
        end else begin
            // Both sides divided down to the 1 MHz compare rate
            if (osc_tick)
                osc_div_q <= osc_pd ? 5'h0 : osc_div_q + 5'h1;
            if (ref_rise)
                ref_div_q <= ref_pd ? 4'h0 : ref_div_q + 4'h1;
            if (ref_pd)
                since_ref_q <= 6'h00;
            else if (since_ref_q != 6'h3F)
                since_ref_q <= since_ref_q + 6'h01;
            slip_q <= 1'b0;
            if (osc_pd) begin
                // Phase error and integrating loop filter
                err_q <= err_now;
                tune_q <= tune_q - {{8{err_now[7]}}, err_now};
                // Any error retards, wrapping round to zero error
                slip_q <= (err_now != 8'sh00);
                locked_q <= (err_now >= -8'sh01) && (err_now <= 8'sh01);
            end
        end
    end
endmodule // tbcr_phase_cmp

// [tbcr_top.v]
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`include "tbcr_defines.vh"

module tbcr_top #(
    parameter NLINES = 7,
    parameter NSIG = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NLINES:0] trig_i,
    output reg [NLINES:0] trig_o,
    output reg [NLINES:0] trig_oe,
    input wire ref_clk10_i,
    input wire [NSIG-1:0] ctl_out_sig,
    output reg [NSIG-1:0] ctl_in_sig,
    output reg master_tick,
    output reg signed [15:0] osc_tune,
    output reg pll_locked
);
    reg [31:0] ctrl_q, out_route_q, in_route_q;
    reg [NLINES:0] trig_s1_q, trig_s2_q;
    reg ref_s1_q, ref_s2_q, ref_s3_q, clk_s3_q;
    reg div_q, ext_seen_q;
    reg aw_hold_q, w_hold_q;
    reg [3:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    wire signed [7:0] err;
    wire signed [15:0] tune;
    wire slip, locked;
    integer i;

    function [31:0] strb_merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer b;
        begin
            strb_merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (strb[b])
                    strb_merge[b*8 +: 8] = data[b*8 +: 8];
        end
    endfunction

    function addr_ok;
        input [3:0] a;
        begin
            addr_ok = (a == `TBCR_CTRL_OFS) || (a == `TBCR_OUT_ROUTE_OFS) ||
                (a == `TBCR_IN_ROUTE_OFS) || (a == `TBCR_STATUS_OFS);
        end
    endfunction

    wire ext_sel = ctrl_q[`TBCR_CTRL_SRC_BIT];
    // Line 7 of the pin group is the bus clock line
    wire bus_clk = trig_s2_q[NLINES];
    wire ext_tick = bus_clk && !clk_s3_q;
    wire ref_rise = ref_s2_q && !ref_s3_q;
    wire int_tick = !div_q && !slip;

    // Pin synchronisers and edge history
    always @(posedge aclk) begin
        if (!aresetn) begin
            trig_s1_q <= {(NLINES+1){1'b0}};
            trig_s2_q <= {(NLINES+1){1'b0}};
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            ref_s3_q <= 1'b0;
            clk_s3_q <= 1'b0;
        end else begin
            trig_s1_q <= trig_i;
            trig_s2_q <= trig_s1_q;
            ref_s1_q <= ref_clk10_i;
            ref_s2_q <= ref_s1_q;
            ref_s3_q <= ref_s2_q;
            clk_s3_q <= bus_clk;
        end
    end

    // Internal 20 MHz timebase, retarded by phase slips
    always @(posedge aclk) begin
        if (!aresetn)
            div_q <= 1'b0;
        else if (!slip)
            div_q <= !div_q;
    end

    // Phase lock always running, no software enable
    tbcr_phase_cmp u_pcmp (
        .aclk(aclk),
        .aresetn(aresetn),
        .osc_tick(int_tick),
        .ref_rise(ref_rise),
        .err_q(err),
        .tune_q(tune),
        .slip_q(slip),
        .locked_q(locked)
    );

    // Timebase selection, routing and pin drive
    always @(posedge aclk) begin
        if (!aresetn) begin
            master_tick <= 1'b0;
            ext_seen_q <= 1'b0;
            trig_o <= {(NLINES+1){1'b0}};
            trig_oe <= {(NLINES+1){1'b0}};
            ctl_in_sig <= {NSIG{1'b0}};
            osc_tune <= 16'sh0000;
            pll_locked <= 1'b0;
        end else begin
            // Never two ticks in a row across a source change
            master_tick <= !master_tick &&
                (ext_sel ? ext_tick : int_tick);
            if (ext_tick)
                ext_seen_q <= 1'b1;
            osc_tune <= tune;
            pll_locked <= locked;
            for (i = 0; i < NLINES; i = i + 1) begin
                trig_oe[i] <= out_route_q[i*4 + `TBCR_FIELD_EN_BIT];
                trig_o[i] <= ctl_out_sig[out_route_q[i*4 +: 2]];
            end
            trig_oe[NLINES] <= !ext_sel &&
                ctrl_q[`TBCR_CTRL_DRIVE_BIT];
            trig_o[NLINES] <= div_q;
            for (i = 0; i < NSIG; i = i + 1)
                ctl_in_sig[i] <= in_route_q[i*4 + `TBCR_FIELD_EN_BIT] &&
                    trig_s2_q[in_route_q[i*4 +: 3]];
        end
    end

    // AXI4-Lite write path
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TBCR_RESP_OKAY;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            ctrl_q <= `TBCR_CTRL_RST;
            out_route_q <= `TBCR_ROUTE_RST;
            in_route_q <= `TBCR_ROUTE_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
                aw_hold_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_hold_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(aw_addr_q) ? `TBCR_RESP_OKAY :
                    `TBCR_RESP_SLVERR;
                case (aw_addr_q)
                    `TBCR_CTRL_OFS: ctrl_q <= strb_merge(ctrl_q, w_data_q,
                        w_strb_q) & 32'h0000_0003;
                    `TBCR_OUT_ROUTE_OFS: out_route_q <= strb_merge(
                        out_route_q, w_data_q, w_strb_q) &
                        32'h0BBB_BBBB;
                    `TBCR_IN_ROUTE_OFS: in_route_q <= strb_merge(
                        in_route_q, w_data_q, w_strb_q) &
                        32'h0000_FFFF;
                    default: ;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // AXI4-Lite read path
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TBCR_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= addr_ok(s_axi_araddr) ? `TBCR_RESP_OKAY :
                    `TBCR_RESP_SLVERR;
                case (s_axi_araddr)
                    `TBCR_CTRL_OFS: s_axi_rdata <= ctrl_q;
                    `TBCR_OUT_ROUTE_OFS: s_axi_rdata <= out_route_q;
                    `TBCR_IN_ROUTE_OFS: s_axi_rdata <= in_route_q;
                    `TBCR_STATUS_OFS: s_axi_rdata <= {tune,
                        err, 5'h00, ext_seen_q, locked, ext_sel};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // tbcr_top

// [tbcr_top_assertions.sv]
module tbcr_top_assertions #(
    parameter NLINES = 7
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NLINES:0] trig_o,
    input wire [NLINES:0] trig_oe,
    input wire master_tick
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_clk_driven;
        trig_oe[NLINES] [*3];
    endsequence
    chk_write_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    chk_write_busy: assert property (s_wr_take |=> !s_axi_awready
        && !s_axi_wready) else $error("write not refused");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read late");
    chk_reset_state: assert property ($rose(aresetn) |-> s_axi_awready
        && s_axi_arready && !s_axi_bvalid && trig_oe == '0)
        else $error("bad state after reset");
    chk_tick_pulse: assert property (master_tick |=> !master_tick)
        else $error("tick too long");
    chk_clk_toggle: assert property (s_clk_driven ##0
        $stable(trig_o[NLINES]) |=> !$stable(trig_o[NLINES]))
        else $error("clock line stuck");
endmodule // tbcr_top_assertions

bind tbcr_top tbcr_top_assertions #(.NLINES(NLINES)) u_chk (.*);

// [trigger_bus_clock_router_test.sv]
`include "tbcr_defines.vh"
module trigger_bus_clock_router_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [2:0] s_axi_awprot = 3'h0;
    logic [2:0] s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, bclk_run = 0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [7:0] drv_en = 8'h80, drv_val = 8'h00;
    logic [3:0] ctl_out_sig = 4'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, master_tick, pll_locked, ref_clk10_i;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0] trig_i, trig_o, trig_oe;
    wire [3:0] ctl_in_sig;
    wire signed [15:0] osc_tune;
    int err_total = 0;
    int samples_checked = 0;
    logic [65:0] rq[$];
    logic [1:0] bq[$];
    tbcr_top DUT (.*);
    tbcr_peer peer (.*);
    always #12.5 aclk = ~aclk;
    task conclude;
        if (err_total == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t response %h", $time, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Only word aligned offsets are mapped
    function automatic logic [1:0] exp_resp(input logic [3:0] a);
        return (a[1:0] == 2'b00) ? `TBCR_RESP_OKAY : `TBCR_RESP_SLVERR;
    endfunction
    task wr(input logic [3:0] a, input logic [31:0] d);
        bq.push_back(exp_resp(a));
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'($urandom_range(1));
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        rq.push_back({m, exp_resp(a), e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($urandom_range(1));
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Scoreboard for bus answers
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready)
            cmp_resp(s_axi_bresp, bq.pop_front());
        if (s_axi_rvalid && s_axi_rready) begin
            cmp_resp(s_axi_rresp, rq[0][33:32]);
            cmp(s_axi_rdata & rq[0][65:34], rq[0][31:0]);
            void'(rq.pop_front());
        end
    end
    initial begin
        int li, si, n;
        logic [7:0] v;
        logic signed [15:0] t;
        void'($urandom(35));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp(32'(trig_oe), 32'h0);
        rd(`TBCR_CTRL_OFS, 32'hffff_ffff, 32'h0);
        rd(`TBCR_STATUS_OFS, 32'h0000_0005, 32'h0);
        cyc(600);
        cmp(32'(pll_locked), 32'h1);
        t = osc_tune;
        cyc(200);
        cmp(32'(osc_tune), 32'(t));
        rd(`TBCR_STATUS_OFS, 32'h0000_0002, 32'h2);
        wr(`TBCR_CTRL_OFS, 32'h2);
        cyc(3);
        cmp(32'(trig_oe), 32'h80);
        wr(`TBCR_CTRL_OFS, 32'h0);
        repeat (8) begin
            li = $urandom_range(6);
            si = $urandom_range(3);
            ctl_out_sig <= 4'($urandom);
            wr(`TBCR_OUT_ROUTE_OFS, (32'h8 | si) << (4 * li));
            cyc(3);
            cmp(32'(trig_oe), 32'(8'h1 << li));
            cmp(32'(trig_o[li]), 32'(ctl_out_sig[si]));
        end
        wr(`TBCR_OUT_ROUTE_OFS, 32'h0);
        cyc(3);
        cmp(32'(trig_oe), 32'h0);
        s_axi_wstrb <= 4'h4;
        wr(`TBCR_OUT_ROUTE_OFS, 32'hffff_ffff);
        s_axi_wstrb <= 4'hf;
        rd(`TBCR_OUT_ROUTE_OFS, 32'hffff_ffff, 32'h00bb_0000);
        wr(4'h2, 32'hffff_ffff);
        rd(4'h2, 32'hffff_ffff, 32'h0);
        rd(`TBCR_CTRL_OFS, 32'hffff_ffff, 32'h0);
        wr(`TBCR_OUT_ROUTE_OFS, 32'h0);
        // Any of lines 0 to 6 can be received on any control signal
        repeat (8) begin
            li = $urandom_range(6);
            si = $urandom_range(3);
            v = 8'($urandom);
            drv_en <= 8'h7f;
            drv_val <= v;
            wr(`TBCR_IN_ROUTE_OFS, (32'h8 | li) << (4 * si));
            cyc(5);
            cmp(32'(ctl_in_sig[si]), 32'(v[li]));
        end
        bclk_run <= 1'b1;
        wr(`TBCR_CTRL_OFS, 32'h3);
        cyc(4);
        cmp(32'(trig_oe[7]), 32'h0);
        n = 0;
        repeat (80) begin
            @(posedge aclk);
            n += master_tick;
        end
        cmp(32'(n >= 9 && n <= 11), 32'h1);
        rd(`TBCR_STATUS_OFS, 32'h0000_0005, 32'h5);
        conclude;
    end
    initial begin
        repeat (4000) @(posedge aclk);
        err_total++;
        conclude;
    end
endmodule // trigger_bus_clock_router_test
